/* hdl/asi_word_checker.v */
// Run of error-free serial-ASI words inside a word window
`timescale 1ns/1ps
`include "lock_detect_defines.vh"

module asi_word_checker (
	input  wire sys_clk,
	input  wire reset_n,
	input  wire clear,
	input  wire word_valid,
	input  wire word_error,
	output reg  asi_ok
);

	reg [6:0] window_count;
	reg [5:0] run_count;
	reg       window_hit;

	always @(posedge sys_clk) begin
		if (!reset_n || clear) begin
			window_count <= 7'h00;
			run_count    <= 6'h00;
			window_hit   <= 1'b0;
			asi_ok       <= 1'b0;
		end else if (word_valid) begin
			window_count <= window_count + 7'h01;
			if (word_error) begin
				run_count <= 6'h00;
			end else if (run_count != `ASI_RUN_NEEDED) begin
				run_count <= run_count + 6'h01;
			end
			// Run of 32 clean words sets lock at once
			if (!word_error && run_count + 6'h01 >= `ASI_RUN_NEEDED) begin
				window_hit <= 1'b1;
				asi_ok     <= 1'b1;
			end else if (window_count == `ASI_WINDOW_LAST) begin
				// Window of 128 words closed without a run
				asi_ok     <= window_hit;
				window_hit <= 1'b0;
				run_count  <= word_error ? 6'h00 : 6'h01;
			end
			if (window_count == `ASI_WINDOW_LAST && !word_error
			    && run_count + 6'h01 >= `ASI_RUN_NEEDED) begin
				window_hit <= 1'b0;
			end
		end
	end

endmodule // asi_word_checker

/* hdl/lock_detect_defines.vh */
// Constants for the serial video lock detector
`ifndef LOCK_DETECT_DEFINES_VH
`define LOCK_DETECT_DEFINES_VH

// Register offsets (byte addresses)
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04

// Control register fields
`define CTRL_AUTO_BIT       0
`define CTRL_RATE_LSB       1
`define CTRL_RATE_MSB       2
`define CTRL_PIN_LSB        4
`define CTRL_PIN_MSB        6
`define CTRL_AUTO_RESET     1'h1
`define CTRL_RATE_RESET     2'h0
`define CTRL_PIN_RESET      3'h3

// Status register fields
`define STAT_LOCK_BIT       0
`define STAT_RATE_LSB       1
`define STAT_RATE_MSB       2
`define STAT_STATE_LSB      3
`define STAT_STATE_MSB      5
`define STAT_TRS_BIT        6
`define STAT_ASI_BIT        7
`define STAT_PLL_BIT        8

// Rate codes
`define RATE_SD             2'h0
`define RATE_HD             2'h1
`define RATE_3G             2'h2

// Status pins
`define STAT_PIN_COUNT      6

// Video timing reference search
`define TRS_NEEDED          2'h2
`define TRS_LINE_WINDOW     2'h2

// Serial-ASI word search
`define ASI_RUN_NEEDED      6'h20
`define ASI_WINDOW_LAST     7'h7F

// Hunt dwell per rate attempt, in lines
`define HUNT_LINES          2'h3

// Signal interruption tolerance: 10 us at the 4 ns clock
`define GAP_CYCLES          12'h9C4

`endif

/* hdl/serial_video_lock_detector.v */
// Lock detection and rate hunting for the serial video receiver
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "lock_detect_defines.vh"

module serial_video_lock_detector (
	input  wire       sys_clk,
	input  wire       reset_n,
	input  wire [7:0] reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire       reg_write,
	input  wire       reg_read,
	output reg  [31:0] reg_rdata,
	input  wire       pll_locked,
	input  wire       signal_present,
	input  wire       standby,
	input  wire       video_processing_select,
	input  wire       asi_mode_select,
	input  wire       trs_seen,
	input  wire       line_start,
	input  wire       asi_word_valid,
	input  wire       asi_word_error,
	input  wire       reclock_bypass_select,
	input  wire       serial_buffered,
	input  wire       serial_retimed,
	output reg  [5:0] stat_pins,
	output reg        serial_loop_output,
	output reg  [1:0] operating_rate,
	output reg        pclk_run,
	output reg        coarse_acq_enable,
	output reg        checker_restart
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_HUNT = 3'b010;
	localparam [2:0] ST_LOCK = 3'b100;

	localparam [11:0] GAP_LIMIT = `GAP_CYCLES;

	// Rate stepping order while hunting
	function [1:0] step_rate;
		input [1:0] rate;
		begin
			case (rate)
				`RATE_3G: step_rate = `RATE_HD;
				`RATE_HD: step_rate = `RATE_SD;
				default:  step_rate = `RATE_3G;
			endcase
		end
	endfunction

	// Lock routed to one status pin
	function [5:0] pin_decode;
		input [2:0] sel;
		input       level;
		begin
			pin_decode = 6'h00;
			if (sel < `STAT_PIN_COUNT) begin
				pin_decode[sel] = level;
			end else begin
				pin_decode[`CTRL_PIN_RESET] = level;
			end
		end
	endfunction

	reg        auto_rate_select;
	reg [1:0]  rate_setting_field;
	reg [2:0]  lock_pin_select;
	reg [2:0]  state;
	reg [2:0]  next_state;
	reg        locked;
	reg        next_locked;
	reg [1:0]  next_rate;
	reg [11:0] gap_count;
	reg [1:0]  hunt_lines;
	reg        next_restart;

	wire       trs_ok;
	wire       asi_ok;
	wire       gap_long;
	wire       sync_ok;
	wire       mode_ok;
	wire       hunt_expired;

	trs_window_checker trs_check (
		.sys_clk    (sys_clk),
		.reset_n    (reset_n),
		.clear      (checker_restart),
		.trs_seen   (trs_seen),
		.line_start (line_start),
		.trs_ok     (trs_ok)
	);

	asi_word_checker asi_check (
		.sys_clk    (sys_clk),
		.reset_n    (reset_n),
		.clear      (checker_restart),
		.word_valid (asi_word_valid),
		.word_error (asi_word_error),
		.asi_ok     (asi_ok)
	);

	// Register writes
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			auto_rate_select   <= `CTRL_AUTO_RESET;
			rate_setting_field <= `CTRL_RATE_RESET;
			lock_pin_select    <= `CTRL_PIN_RESET;
		end else if (reg_write && reg_addr == `REG_CTRL) begin
			auto_rate_select   <= reg_wdata[`CTRL_AUTO_BIT];
			rate_setting_field <= reg_wdata[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
			lock_pin_select    <= reg_wdata[`CTRL_PIN_MSB:`CTRL_PIN_LSB];
		end
	end

	// Register reads, data one cycle after the strobe
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read) begin
			reg_rdata <= 32'h00000000;
			case (reg_addr)
				`REG_CTRL: begin
					reg_rdata[`CTRL_AUTO_BIT]               <= auto_rate_select;
					reg_rdata[`CTRL_RATE_MSB:`CTRL_RATE_LSB] <= rate_setting_field;
					reg_rdata[`CTRL_PIN_MSB:`CTRL_PIN_LSB]   <= lock_pin_select;
				end
				`REG_STATUS: begin
					reg_rdata[`STAT_LOCK_BIT]                  <= locked;
					reg_rdata[`STAT_RATE_MSB:`STAT_RATE_LSB]   <= operating_rate;
					reg_rdata[`STAT_STATE_MSB:`STAT_STATE_LSB] <= state;
					reg_rdata[`STAT_TRS_BIT]                   <= trs_ok;
					reg_rdata[`STAT_ASI_BIT]                   <= asi_ok;
					reg_rdata[`STAT_PLL_BIT]                   <= pll_locked;
				end
				default: begin
					reg_rdata <= 32'h00000000;
				end
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// Input interruption timer; saturates at the tolerance
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			gap_count <= 12'h000;
		end else if (signal_present) begin
			gap_count <= 12'h000;
		end else if (gap_count != GAP_LIMIT) begin
			gap_count <= gap_count + 12'h001;
		end
	end

	assign gap_long = (gap_count == GAP_LIMIT);

	// Sync condition for the selected mode
	assign sync_ok = asi_mode_select ? asi_ok : trs_ok;
	// ASI in auto mode uses the same run check, which some
	// patterns can break while still valid
	assign mode_ok = (!video_processing_select && !asi_mode_select) ? pll_locked
	               : (pll_locked && sync_ok);

	// Hunt dwell: three lines per attempt
	always @(posedge sys_clk) begin
		if (!reset_n || state != ST_HUNT || checker_restart) begin
			hunt_lines <= 2'h0;
		end else if (line_start && hunt_lines != `HUNT_LINES) begin
			hunt_lines <= hunt_lines + 2'h1;
		end
	end

	// Masked while the restart pulse stands, so one dwell steps the rate once
	assign hunt_expired = (hunt_lines == `HUNT_LINES) && !mode_ok && !checker_restart;

	// Next state and lock level
	always @* begin
		next_state   = state;
		next_locked  = locked;
		next_rate    = operating_rate;
		next_restart = 1'b0;
		if (!auto_rate_select) begin
			next_rate = rate_setting_field;
		end
		case (state)
			ST_IDLE: begin
				next_locked = 1'b0;
				if (signal_present) begin
					next_state   = ST_HUNT;
					next_restart = 1'b1;
				end
			end
			ST_HUNT: begin
				next_locked = 1'b0;
				if (gap_long) begin
					next_state = ST_IDLE;
				end else if (mode_ok) begin
					next_state  = ST_LOCK;
					next_locked = 1'b1;
				end else if (hunt_expired) begin
					next_restart = 1'b1;
					if (auto_rate_select) begin
						next_rate = step_rate(operating_rate);
					end
				end
			end
			ST_LOCK: begin
				next_locked = 1'b1;
				if (gap_long) begin
					// Rate may be lost; hunt again from no signal
					next_state  = ST_IDLE;
					next_locked = 1'b0;
				end else if (!signal_present) begin
					next_locked = 1'b1;
				end else if (!mode_ok) begin
					next_state   = ST_HUNT;
					next_locked  = 1'b0;
					next_restart = 1'b1;
				end
			end
			default: begin
				next_state  = ST_IDLE;
				next_locked = 1'b0;
			end
		endcase
	end

	// Main sequencer; standby freezes the lock level and rate, forces ST_IDLE and holds the checker restart
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			state           <= ST_IDLE;
			locked          <= 1'b0;
			operating_rate  <= `RATE_3G;
			checker_restart <= 1'b1;
		end else if (standby) begin
			// PLL drops in standby; hold the lock level
			state           <= ST_IDLE;
			locked          <= locked;
			checker_restart <= 1'b1;
		end else begin
			state           <= next_state;
			locked          <= next_locked;
			operating_rate  <= next_rate;
			checker_restart <= next_restart;
		end
	end

	// Status pins, serial loop-through and clock controls
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			stat_pins          <= 6'h00;
			serial_loop_output <= 1'b0;
			pclk_run           <= 1'b0;
			coarse_acq_enable  <= 1'b0;
		end else begin
			stat_pins <= pin_decode(lock_pin_select, next_locked_out(standby));
			// Bypass choice touches only the loop-through path
			if (!reclock_bypass_select) begin
				serial_loop_output <= serial_buffered;
			end else if (!pll_locked) begin
				serial_loop_output <= 1'b0;
			end else begin
				serial_loop_output <= serial_retimed;
			end
			// Parallel clock never gated by rate changes
			pclk_run <= 1'b1;
			// Reference only steers acquisition before lock
			coarse_acq_enable <= !pll_locked && !standby;
		end
	end

	// Lock level seen on the pin in the same cycle as the flop
	function next_locked_out;
		input sb;
		begin
			next_locked_out = sb ? locked : next_locked;
		end
	endfunction

endmodule // serial_video_lock_detector

/* hdl/trs_window_checker.v */
// Two timing reference words within a two-line span
`timescale 1ns/1ps
`include "lock_detect_defines.vh"

module trs_window_checker (
	input  wire sys_clk,
	input  wire reset_n,
	input  wire clear,
	input  wire trs_seen,
	input  wire line_start,
	output reg  trs_ok
);

	reg [1:0] trs_count;
	reg [1:0] line_count;

	always @(posedge sys_clk) begin
		if (!reset_n || clear) begin
			trs_count  <= 2'h0;
			line_count <= 2'h0;
			trs_ok     <= 1'b0;
		end else if (trs_seen) begin
			line_count <= 2'h0;
			if (trs_count != `TRS_NEEDED) begin
				trs_count <= trs_count + 2'h1;
			end
			// Second word inside the span gives lock
			if (trs_count + 2'h1 >= `TRS_NEEDED) begin
				trs_ok <= 1'b1;
			end
		end else if (line_start) begin
			// Two lines with no word: start over
			if (line_count + 2'h1 >= `TRS_LINE_WINDOW) begin
				line_count <= 2'h0;
				trs_count  <= 2'h0;
				trs_ok     <= 1'b0;
			end else begin
				line_count <= line_count + 2'h1;
			end
		end
	end

endmodule // trs_window_checker

/* verif/lock_detect_properties.sv */
// Port checker for the lock detector
`timescale 1ns/1ps
module lock_detect_properties (
	input logic       sys_clk,
	input logic       reset_n,
	input logic       pll_locked,
	input logic       signal_present,
	input logic       standby,
	input logic       video_processing_select,
	input logic       asi_mode_select,
	input logic       reclock_bypass_select,
	input logic       serial_buffered,
	input logic       serial_retimed,
	input logic [5:0] stat_pins,
	input logic       serial_loop_output,
	input logic [1:0] operating_rate,
	input logic       pclk_run,
	input logic       coarse_acq_enable,
	input logic       checker_restart
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic [11:0] gap_cnt;
	// Idle input time; standby excluded since it freezes the level
	always @(posedge sys_clk)
		if (!reset_n || signal_present || standby) gap_cnt <= 12'h000;
		else if (gap_cnt != 12'hFFF) gap_cnt <= gap_cnt + 12'h001;
	a_one_pin: assert property ($onehot0(stat_pins))
		else $error("lock shown on more than one pin");
	a_thru_lock: assert property ((signal_present && pll_locked && !standby && !video_processing_select
		&& !asi_mode_select) [*4] |=> stat_pins != 6'h00) else $error("pass-through lock missing");
	a_standby_hold: assert property (standby |=> $stable(stat_pins))
		else $error("lock moved in standby");
	a_gap_drop: assert property (gap_cnt == 12'h9C5 |-> stat_pins == 6'h00)
		else $error("lock kept without input");
	a_pclk_alive: assert property ($past(reset_n) |-> pclk_run)
		else $error("parallel clock stopped");
	a_loop_buffer: assert property (!reclock_bypass_select |=> serial_loop_output == $past(serial_buffered))
		else $error("buffered loop bit wrong");
	a_loop_retime: assert property (reclock_bypass_select && pll_locked |=> serial_loop_output == $past(serial_retimed))
		else $error("retimed loop bit wrong");
	a_coarse_ref: assert property (1'b1 |=> coarse_acq_enable == (!$past(pll_locked) && !$past(standby)))
		else $error("reference use wrong");
	a_loop_mute: assert property (reclock_bypass_select && !pll_locked |=> !serial_loop_output)
		else $error("loop output not muted");
	a_reset_clear: assert property (@(posedge sys_clk) disable iff (1'b0) !reset_n
		|=> stat_pins == 6'h00 && checker_restart && operating_rate == 2'h2) else $error("reset not clean");
	c_lock: cover property (stat_pins != 6'h00 && $past(stat_pins) == 6'h00);
	c_rate: cover property (!$stable(operating_rate));
	c_hold: cover property (standby && stat_pins != 6'h00);
endmodule // lock_detect_properties
bind serial_video_lock_detector lock_detect_properties i_props (.sys_clk, .reset_n, .pll_locked, .signal_present,
	.standby, .video_processing_select, .asi_mode_select, .reclock_bypass_select, .serial_buffered, .serial_retimed,
	.stat_pins,
	.serial_loop_output, .operating_rate, .pclk_run, .coarse_acq_enable, .checker_restart);

/* verif/tb_top.sv */
// Self-checking bench for the lock detector
`timescale 1ns/1ps
`include "lock_detect_defines.vh"
module tb_top;
	logic        sys_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic        pll_locked = 1'b0, signal_present = 1'b0, standby = 1'b0, reclock_bypass_select = 1'b0;
	logic        video_processing_select = 1'b0, asi_mode_select = 1'b0, trs_on = 1'b0, asi_bad = 1'b0;
	logic [5:0]  stat_pins;
	logic [1:0]  operating_rate;
	logic        trs_seen, line_start, asi_word_valid, asi_word_error, serial_buffered, serial_retimed;
	logic        serial_loop_output, pclk_run, coarse_acq_enable, checker_restart;
	int          fails = 0, samples_checked = 0;
	serial_video_lock_detector i_dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .pll_locked, .signal_present, .standby, .video_processing_select, .asi_mode_select,
		.trs_seen, .line_start, .asi_word_valid, .asi_word_error, .reclock_bypass_select, .serial_buffered,
		.serial_retimed, .stat_pins, .serial_loop_output, .operating_rate, .pclk_run, .coarse_acq_enable,
		.checker_restart);
	video_source i_src (.sys_clk, .trs_on, .asi_bad, .trs_seen, .line_start, .asi_word_valid, .asi_word_error,
		.serial_buffered, .serial_retimed);
	initial forever #2 sys_clk = ~sys_clk;
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk) reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk) reg_read <= 1'b0;
		@(negedge sys_clk) check(reg_rdata, exp);
		@(posedge sys_clk);
	endtask
	// Bounded waits; a spent bound ends the run
	task automatic wait_pins(input logic [5:0] exp, input int lim);
		for (int i = 0; i < lim && stat_pins !== exp; i++) @(negedge sys_clk);
		check({26'h0, stat_pins}, {26'h0, exp});
		if (stat_pins !== exp) give_verdict();
		@(posedge sys_clk);
	endtask
	task automatic wait_rate(input logic [1:0] r);
		for (int i = 0; i < 80 && operating_rate !== r; i++) @(negedge sys_clk);
		check({30'h0, operating_rate}, {30'h0, r});
		if (operating_rate !== r) give_verdict();
		@(posedge sys_clk);
	endtask
	task automatic restart();
		standby <= 1'b1;
		cyc(2);
		standby <= 1'b0;
		wait_pins(6'h00, 80);
	endtask
	initial begin
		cyc(100000);
		fails++;
		give_verdict();
	end
	initial begin
		cyc(10);
		reset_n <= 1'b1;
		cyc(1);
		rd(`REG_CTRL, 32'h31);
		check({30'h0, operating_rate}, {30'h0, `RATE_3G});
		wr(8'h10, 32'hFF);
		rd(8'h10, 32'h0);
		rd(`REG_CTRL, 32'h31);
		$display("registers done");
		signal_present <= 1'b1;
		cyc(20);
		check({26'h0, stat_pins}, 32'h0);
		pll_locked <= 1'b1;
		wait_pins(6'h08, 4);
		for (int p = 0; p < 8; p++) begin
			wr(`REG_CTRL, 32'h1 | (32'(p) << 4));
			cyc(2);
			check({26'h0, stat_pins}, (p < 6) ? 32'h1 << p : 32'h8);
		end
		wr(`REG_CTRL, 32'h31);
		rd(`REG_STATUS, 32'h1A5);
		$display("pass-through and pins done");
		reclock_bypass_select <= 1'b1;
		standby <= 1'b1;
		pll_locked <= 1'b0;
		cyc(20);
		check({26'h0, stat_pins}, 32'h8);
		standby <= 1'b0;
		wait_pins(6'h00, 10);
		pll_locked <= 1'b1;
		reclock_bypass_select <= 1'b0;
		wait_pins(6'h08, 6);
		signal_present <= 1'b0;
		cyc(2490);
		check({26'h0, stat_pins}, 32'h8);
		wait_pins(6'h00, 20);
		$display("standby and gap done");
		video_processing_select <= 1'b1;
		reclock_bypass_select <= 1'b1;
		signal_present <= 1'b1;
		wait_rate(`RATE_HD);
		wait_rate(`RATE_SD);
		wait_rate(`RATE_3G);
		check({26'h0, stat_pins}, 32'h0);
		trs_on <= 1'b1;
		wait_pins(6'h08, 200);
		wr(`REG_CTRL, 32'h32);
		trs_on <= 1'b0;
		restart();
		cyc(200);
		check({30'h0, operating_rate}, {30'h0, `RATE_HD});
		trs_on <= 1'b1;
		wait_pins(6'h08, 60);
		$display("video hunt done");
		video_processing_select <= 1'b0;
		asi_mode_select <= 1'b1;
		asi_bad <= 1'b1;
		restart();
		cyc(300);
		check({26'h0, stat_pins}, 32'h0);
		asi_bad <= 1'b0;
		wait_pins(6'h08, 300);
		reset_n <= 1'b0;
		cyc(2);
		check({26'h0, stat_pins}, 32'h0);
		reset_n <= 1'b1;
		cyc(1);
		rd(`REG_CTRL, 32'h31);
		wait_pins(6'h08, 400);
		$display("serial words and reset done");
		give_verdict();
	end
endmodule // tb_top

/* verif/video_source.sv */
// Incoming serial stream model: lines, timing words, ASI words
`timescale 1ns/1ps
module video_source (
	input  logic sys_clk,
	input  logic trs_on,
	input  logic asi_bad,
	output logic trs_seen = 1'b0,
	output logic line_start = 1'b0,
	output logic asi_word_valid = 1'b0,
	output logic asi_word_error = 1'b0,
	output logic serial_buffered = 1'b0,
	output logic serial_retimed = 1'b0
);
	logic [3:0] tick = 4'h0;
	// Short 16-cycle lines keep hunt runs brief
	always @(posedge sys_clk) begin
		tick <= tick + 4'h1;
		line_start <= (tick == 4'h0);
		trs_seen <= trs_on && (tick == 4'h8);
		asi_word_valid <= 1'b1;
		asi_word_error <= asi_bad;
		serial_buffered <= tick[1];
		serial_retimed <= tick[2];
	end
endmodule // video_source
